// ---- host_port_irq_defs.vh ----
// constants for the host port and interrupt request block
// assumes it is included by the block's design file only
// Overview of operation
// (RULE1) serial mode: read data leaves on the serial output, one bit per active edge
// (RULE2) serial output moves on shift clock rise if edge select low, fall if high
// (RULE3) one request output merges every internal interrupt source
// (RULE4) global mask bit set to one blocks all sources from the request output
// (RULE5) two mask registers at 11h and 12h mask single sources independently
// (RULE6) status readable as channel summary 80h and status registers 16h and 17h
// (RULE7) two config bits pick push-pull high, push-pull low or open-drain low request
// (RULE8) data bus driven by the device only in read cycles, by the host in writes
// (RULE9) host presents the register address on eight address lines in every parallel access
// (RULE10) request held while any unmasked status bit is set, released otherwise
`ifndef HOST_PORT_IRQ_DEFS_VH
`define HOST_PORT_IRQ_DEFS_VH
// register offsets
`define ADDR_INTERRUPT_MASK_LOW 8'h11
`define ADDR_INTERRUPT_MASK_HIGH 8'h12
`define ADDR_INTERRUPT_STATUS_LOW 8'h16
`define ADDR_INTERRUPT_STATUS_HIGH 8'h17
`define ADDR_GLOBAL_CONFIG_ZERO 8'h40
`define ADDR_CHANNEL_INTERRUPT_SUMMARY 8'h80
// reset values
`define RST_INTERRUPT_MASK 8'hff
`define RST_GLOBAL_CONFIG_ZERO 8'h00
// field positions in global_config_zero
`define GCF_IRQ_PIN_LSB 0
`define GCF_IRQ_PIN_MSB 1
`define GCF_GLOBAL_IRQ_MASK_BIT 2
// request pin types
`define IRQ_PIN_OPEN_DRAIN_LOW 2'h0
`define IRQ_PIN_PUSH_PULL_LOW 2'h1
`define IRQ_PIN_PUSH_PULL_HIGH 2'h2
// serial frame: 8 address bits, 1 read flag, 8 data bits
`define SER_ADDR_BITS 5'h08
`define SER_LAST_BIT 5'h10
`endif

// ---- host_port_irq.v ----
// host port pins and interrupt request logic of the line interface
// assumes all pins are asynchronous to i_clk_sys and the shift clock is well below 125 MHz
`timescale 1ns/1ps
`include "host_port_irq_defs.vh"

module host_port_irq #(
  parameter NSRC = 16 // interrupt sources, four per channel
) (
  input wire i_clk_sys, // system clock
  input wire i_reset_n, // asynchronous reset, active low
  input wire i_clk_en, // freezes all state while low
  input wire i_serial_mode, // pin: 1 serial host port, 0 parallel
  input wire i_cs_n, // pin: chip select, active low
  input wire i_sclk, // pin: serial shift clock
  input wire i_sdi, // pin: serial data in
  input wire i_shift_edge_select_pin, // pin: 0 rise, 1 fall for serial out
  input wire i_rd_n, // pin: parallel read strobe, active low
  input wire i_wr_n, // pin: parallel write strobe, active low
  input wire [7:0] i_addr, // pin: address bus, host_addr_bit_seven is bit 7
  input wire [7:0] i_data, // pin: data bus level as seen on the wire
  input wire [NSRC-1:0] i_irq_src, // internal interrupt events, one-cycle pulses
  output reg [7:0] o_data, // data bus drive value
  output reg o_data_oe_n, // data bus enable, low while driving
  output reg o_serial_out_pin, // serial data out
  output reg o_irq, // request pin drive value
  output reg o_irq_oe_n // request pin enable, low while driving
);

  ////////////////////////////////////////////////////////////////////////
  // reset release and pin synchronisers
  reg [1:0] rst_q;
  wire rst_n = rst_q[1];
  reg [7:0] meta_q; // first stage, read only by sync_q
  reg [7:0] sync_q;
  reg [7:0] addr_meta_q;
  reg [7:0] addr_q;
  reg [7:0] data_meta_q;
  reg [7:0] din_q;
  reg [7:0] prev_q;

  // reset held two cycles after release
  always @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_q <= 2'h0;
    end else if (i_clk_en) begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end

  // two flops on every pin
  always @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      // idle pin levels, so no false strobe or shift edge follows reset
      meta_q <= 8'h43;
      sync_q <= 8'h43;
      prev_q <= 8'h43;
      addr_meta_q <= 8'h00;
      addr_q <= 8'h00;
      data_meta_q <= 8'h00;
      din_q <= 8'h00;
    end else if (i_clk_en) begin
      meta_q <= {1'b0, i_cs_n, i_serial_mode, i_shift_edge_select_pin, i_sdi, i_sclk, i_rd_n, i_wr_n};
      sync_q <= meta_q;
      prev_q <= sync_q;
      addr_meta_q <= i_addr; // RULE9
      addr_q <= addr_meta_q;
      data_meta_q <= i_data;
      din_q <= data_meta_q;
    end
  end

  // strobes are gated with chip select only after both pass the synchroniser
  wire cs_s = sync_q[6];
  wire wr_s = sync_q[0] | cs_s;
  wire rd_s = sync_q[1] | cs_s;
  wire sclk_s = sync_q[2];
  wire sdi_s = sync_q[3];
  wire edge_sel = sync_q[4];
  wire ser_mode = sync_q[5];
  wire wr_prev = prev_q[0] | prev_q[6];
  wire rd_prev = prev_q[1] | prev_q[6];
  wire wr_rise = wr_s & ~wr_prev & ~ser_mode;
  wire rd_fall = ~rd_s & rd_prev & ~ser_mode;
  wire sclk_rise = sclk_s & ~prev_q[2];
  wire sclk_fall = ~sclk_s & prev_q[2];

  ////////////////////////////////////////////////////////////////////////
  // chip select for serial mode, from the same synchroniser as the strobes
  wire ser_sel = ser_mode & ~cs_s;

  ////////////////////////////////////////////////////////////////////////
  // registers and status
  reg [7:0] mask_lo_q;
  reg [7:0] mask_hi_q;
  reg [7:0] gcf_q;
  reg [NSRC-1:0] status_q;
  reg [4:0] cnt_q;
  reg [7:0] saddr_q;
  reg [7:0] swdata_q;
  reg [7:0] sshift_q;
  reg read_flag_q;

  wire [15:0] mask_all = {mask_hi_q, mask_lo_q};
  wire [15:0] status_all = status_q;
  wire [3:0] chan_sum;

  // per channel summary bit: any status of that channel's four sources
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_chan
      assign chan_sum[g] = |status_all[4*g+3:4*g]; // RULE6
    end
  endgenerate

  // read value for any address
  function [7:0] read_mux;
    input [7:0] a;
    begin
      case (a)
        `ADDR_INTERRUPT_MASK_LOW: read_mux = mask_lo_q;
        `ADDR_INTERRUPT_MASK_HIGH: read_mux = mask_hi_q;
        `ADDR_INTERRUPT_STATUS_LOW: read_mux = status_all[7:0]; // RULE6
        `ADDR_INTERRUPT_STATUS_HIGH: read_mux = status_all[15:8]; // RULE6
        `ADDR_GLOBAL_CONFIG_ZERO: read_mux = gcf_q;
        `ADDR_CHANNEL_INTERRUPT_SUMMARY: read_mux = {4'h0, chan_sum}; // RULE6
        default: read_mux = 8'h00;
      endcase
    end
  endfunction

  // serial frame decode
  wire ser_bit = ser_sel & sclk_rise & (cnt_q <= `SER_LAST_BIT);
  wire ser_load = ser_bit & (cnt_q == `SER_ADDR_BITS) & sdi_s;
  wire ser_write = ser_bit & (cnt_q == `SER_LAST_BIT) & ~read_flag_q;
  wire [7:0] ser_wdata = {swdata_q[6:0], sdi_s};
  wire ser_shift = ser_sel & read_flag_q & (cnt_q <= `SER_LAST_BIT) & (edge_sel ? sclk_fall : sclk_rise); // no shift past bit 0

  // one write port shared by both host modes
  wire do_write = wr_rise | ser_write;
  wire [7:0] w_addr = ser_mode ? saddr_q : addr_q;
  wire [7:0] w_data = ser_mode ? ser_wdata : din_q;
  wire do_read = rd_fall | ser_load;
  wire [7:0] r_addr = ser_mode ? saddr_q : addr_q;

  // writable registers
  always @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mask_lo_q <= `RST_INTERRUPT_MASK;
      mask_hi_q <= `RST_INTERRUPT_MASK;
      gcf_q <= `RST_GLOBAL_CONFIG_ZERO;
    end else if (i_clk_en && do_write) begin
      if (w_addr == `ADDR_INTERRUPT_MASK_LOW) begin
        mask_lo_q <= w_data; // RULE5
      end
      if (w_addr == `ADDR_INTERRUPT_MASK_HIGH) begin
        mask_hi_q <= w_data; // RULE5
      end
      if (w_addr == `ADDR_GLOBAL_CONFIG_ZERO) begin
        gcf_q <= w_data; // RULE4 RULE7
      end
    end
  end

  // sticky status, cleared by a read of its register, a new event wins
  wire clr_lo = do_read & (r_addr == `ADDR_INTERRUPT_STATUS_LOW);
  wire clr_hi = do_read & (r_addr == `ADDR_INTERRUPT_STATUS_HIGH);
  wire [15:0] clr_mask = {{8{clr_hi}}, {8{clr_lo}}};
  always @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= {NSRC{1'b0}};
    end else if (i_clk_en) begin
      status_q <= (status_q & ~clr_mask[NSRC-1:0]) | i_irq_src; // RULE3
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // serial host port
  always @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 5'h00;
      saddr_q <= 8'h00;
      swdata_q <= 8'h00;
      sshift_q <= 8'h00;
      read_flag_q <= 1'b0;
      o_serial_out_pin <= 1'b0;
    end else if (i_clk_en) begin
      if (!ser_sel) begin
        cnt_q <= 5'h00;
        read_flag_q <= 1'b0;
      end else if (ser_bit) begin
        cnt_q <= cnt_q + 5'h01;
        if (cnt_q < `SER_ADDR_BITS) begin
          saddr_q <= {saddr_q[6:0], sdi_s};
        end else if (cnt_q == `SER_ADDR_BITS) begin
          read_flag_q <= sdi_s;
        end else begin
          swdata_q <= ser_wdata;
        end
      end
      // load has priority over a shift on the same edge
      if (ser_load) begin
        sshift_q <= read_mux(saddr_q); // RULE1
      end else if (ser_shift) begin // RULE2
        o_serial_out_pin <= sshift_q[7]; // RULE1
        sshift_q <= {sshift_q[6:0], 1'b0};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // parallel data bus: driven only while a read strobe is low
  always @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      o_data <= 8'h00;
      o_data_oe_n <= 1'b1;
    end else if (i_clk_en) begin
      if (rd_fall) begin
        o_data <= read_mux(addr_q);
      end
      o_data_oe_n <= rd_s | ser_mode | ~wr_s; // RULE8
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupt request pin
  wire [1:0] pin_type = gcf_q[`GCF_IRQ_PIN_MSB:`GCF_IRQ_PIN_LSB];
  wire irq_req = ~gcf_q[`GCF_GLOBAL_IRQ_MASK_BIT] & |(status_all[NSRC-1:0] & ~mask_all[NSRC-1:0]); // RULE4 RULE10
  always @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      o_irq <= 1'b0;
      o_irq_oe_n <= 1'b1;
    end else if (i_clk_en) begin
      case (pin_type) // RULE7
        `IRQ_PIN_OPEN_DRAIN_LOW: begin
          o_irq <= 1'b0;
          o_irq_oe_n <= ~irq_req; // RULE3
        end
        `IRQ_PIN_PUSH_PULL_LOW: begin
          o_irq <= ~irq_req;
          o_irq_oe_n <= 1'b0;
        end
        default: begin
          o_irq <= irq_req;
          o_irq_oe_n <= 1'b0;
        end
      endcase
    end
  end

endmodule // host_port_irq

// ---- host_port_irq_sva.sv ----
// checker for the host port pins of host_port_irq
// assumes a bind to the design top from the bench
`timescale 1ns/1ps
module host_port_irq_sva #(
  parameter NSRC = 16 // sources
) (
  input wire i_clk_sys, // clock
  input wire i_reset_n, // reset
  input wire i_serial_mode, // mode
  input wire i_cs_n, // select
  input wire i_sclk, // shift clock
  input wire i_shift_edge_select_pin, // edge
  input wire i_rd_n, // read
  input wire i_wr_n, // write
  input wire [NSRC-1:0] i_irq_src, // events
  input wire [7:0] o_data, // bus value
  input wire o_data_oe_n, // bus enable
  input wire o_serial_out_pin, // serial out
  input wire o_irq, // request
  input wire o_irq_oe_n // request enable
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);
  ////////////////////////////////////////
  // data bus driven only inside reads
  chk_bus_rd_on: assert property ($fell(i_rd_n) && !i_cs_n && !i_serial_mode |-> ##[2:5] !o_data_oe_n)
    else $error("bus not driven in read");
  chk_bus_rd_off: assert property (i_rd_n [*6] |-> o_data_oe_n)
    else $error("bus driven after read");
  chk_bus_wr_off: assert property ((!i_wr_n && !i_cs_n) [*4] |-> o_data_oe_n)
    else $error("bus driven in write");
  chk_rd_data_hold: assert property (!o_data_oe_n && !$past(o_data_oe_n) |-> $stable(o_data))
    else $error("read data moved");
  // serial output moves only after the selected shift edge
  chk_sdo_on_edge: assert property ($changed(o_serial_out_pin) |-> $past(i_sclk, 2) != $past(i_sclk, 6))
    else $error("serial out moved without edge");
  chk_sdo_rise_sel: assert property ($changed(o_serial_out_pin) && !i_shift_edge_select_pin |-> $past(i_sclk, 2))
    else $error("serial out not on rise");
  chk_sdo_fall_sel: assert property ($changed(o_serial_out_pin) && i_shift_edge_select_pin |-> !$past(i_sclk, 2))
    else $error("serial out not on fall");
  // request pin holds while nothing happens
  chk_irq_idle_hold: assert property ((i_irq_src == 0 && i_cs_n) [*8] |-> $stable({o_irq, o_irq_oe_n}))
    else $error("request moved while idle");
endmodule // host_port_irq_sva

// ---- host_port_mcu.sv ----
// host model on the parallel and serial port
// assumes calls from one bench process at falling edges
`timescale 1ns/1ps
module host_port_mcu (
  input wire i_clk, // clock
  input wire [7:0] i_dev_data, // device bus value
  input wire i_dev_oe_n, // device drives, low
  input wire i_sdo, // serial out
  output logic o_serial_mode = 0, // mode
  output logic o_cs_n = 1, // select
  output logic o_sclk = 0, // still between frames
  output logic o_sdi = 0, // serial in
  output logic o_edge_sel = 0, // out edge
  output logic o_rd_n = 1, // read
  output logic o_wr_n = 1, // write
  output logic [7:0] o_addr = 0, // address
  output logic [7:0] o_bus // bus level
);
  logic drv = 0;
  logic [7:0] hd = 0;
  logic [7:0] flt = 0;
  // released bus shows a level that changes every cycle
  always @* o_bus = !i_dev_oe_n ? i_dev_data : drv ? hd : flt;
  always @(posedge i_clk) flt <= ~o_bus;
  task automatic wt(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  ////////////////////////////////////////
  // write: host drives the bus only here
  task automatic par_write(input logic [7:0] a, input logic [7:0] d);
    o_addr = a;
    hd = d;
    drv = 1;
    o_cs_n = 0;
    o_wr_n = 0;
    wt(8);
    o_wr_n = 1;
    wt(6);
    o_cs_n = 1;
    drv = 0;
    wt(6);
  endtask
  task automatic par_read(input logic [7:0] a, output logic [7:0] d);
    o_addr = a;
    o_cs_n = 0;
    o_rd_n = 0;
    wt(8);
    d = o_bus;
    o_rd_n = 1;
    o_cs_n = 1;
    wt(8);
  endtask
  // serial frame: address, read flag, data, all msb first
  task automatic ser_frame(input logic sel, input logic [7:0] a, input logic r, input logic [7:0] wd,
    output logic [7:0] rb);
    o_serial_mode = 1;
    o_edge_sel = sel;
    wt(6);
    o_cs_n = 0;
    for (int i = 0; i < 17; i++) begin
      o_sclk = 0;
      o_sdi = i < 8 ? a[7 - i] : i == 8 ? r : wd[16 - i];
      wt(8);
      if (i > 8 && sel) rb = {rb[6:0], i_sdo};
      o_sclk = 1;
      wt(8);
      if (i > 8 && !sel) rb = {rb[6:0], i_sdo};
    end
    o_sclk = 0;
    wt(8);
    o_cs_n = 1;
    o_serial_mode = 0;
    wt(8);
  endtask
endmodule // host_port_mcu

// ---- tb_host_port_irq.sv ----
// bench for host_port_irq: registers, request pin, serial port
// assumes host_port_mcu as host and the checker bound at the foot
`timescale 1ns/1ps
`define CHK(e, g) begin n_checks++; if ((g) !== (e)) begin bad_count++; $display("CHECK FAILED %s exp %h got %h", tname, e, g); end end
module tb_host_port_irq;
  logic i_clk_sys = 0;
  logic i_reset_n = 0;
  logic i_clk_en = 1;
  logic [15:0] i_irq_src = 0;
  wire i_serial_mode, i_cs_n, i_sclk, i_sdi, i_shift_edge_select_pin, i_rd_n, i_wr_n;
  wire o_data_oe_n, o_serial_out_pin, o_irq, o_irq_oe_n;
  wire [7:0] i_addr, i_data, o_data;
  wire irq_level = o_irq_oe_n ? 1'b1 : o_irq; // pulled up when released
  int bad_count = 0;
  int n_checks = 0;
  int seed = 70;
  logic [7:0] exp_q[$];
  logic [7:0] got, e, v, sr;
  logic [7:0] rst_a[7] = '{8'h11, 8'h12, 8'h16, 8'h17, 8'h40, 8'h80, 8'h33};
  logic [7:0] rst_v[7] = '{8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  string tname = "reset";
  event got_ev;
  initial forever #2 i_clk_sys = ~i_clk_sys;
  host_port_irq #(.NSRC(16)) i_host_port_irq (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_clk_en(i_clk_en),
    .i_serial_mode(i_serial_mode), .i_cs_n(i_cs_n), .i_sclk(i_sclk), .i_sdi(i_sdi),
    .i_shift_edge_select_pin(i_shift_edge_select_pin), .i_rd_n(i_rd_n), .i_wr_n(i_wr_n), .i_addr(i_addr),
    .i_data(i_data), .i_irq_src(i_irq_src), .o_data(o_data), .o_data_oe_n(o_data_oe_n),
    .o_serial_out_pin(o_serial_out_pin), .o_irq(o_irq), .o_irq_oe_n(o_irq_oe_n));
  host_port_mcu i_host_port_mcu (.i_clk(i_clk_sys), .i_dev_data(o_data), .i_dev_oe_n(o_data_oe_n),
    .i_sdo(o_serial_out_pin), .o_serial_mode(i_serial_mode), .o_cs_n(i_cs_n), .o_sclk(i_sclk), .o_sdi(i_sdi),
    .o_edge_sel(i_shift_edge_select_pin), .o_rd_n(i_rd_n), .o_wr_n(i_wr_n), .o_addr(i_addr), .o_bus(i_data));
  ////////////////////////////////////////
  // each posted result is compared with the oldest note
  initial forever begin
    @(got_ev);
    e = exp_q.pop_front();
    `CHK(e, got)
  end
  task automatic post(input logic [7:0] g);
    got = g;
    -> got_ev;
    @(negedge i_clk_sys);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    logic [7:0] d;
    exp_q.push_back(x);
    i_host_port_mcu.par_read(a, d);
    post(d);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_host_port_mcu.par_write(a, d);
  endtask
  // request pin as {enable, wire level}, after the pin latency
  task automatic pin(input logic [1:0] x);
    repeat (3) @(negedge i_clk_sys);
    exp_q.push_back({6'h00, x});
    post({6'h00, o_irq_oe_n, irq_level});
  endtask
  task automatic pulse(input logic [15:0] s);
    i_irq_src = s;
    @(negedge i_clk_sys);
    i_irq_src = 0;
  endtask
  task automatic done(input string n);
    $display("test %s done", tname);
    tname = n;
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  ////////////////////////////////////////
  // watchdog and the test sequence
  initial begin
    fork
      begin
        repeat (40000) @(posedge i_clk_sys);
        bad_count++;
        print_verdict();
      end
    join_none
    repeat (16) @(negedge i_clk_sys);
    i_reset_n = 1;
    repeat (6) @(negedge i_clk_sys);
    wr(8'h16, 8'h5a);
    for (int k = 0; k < 7; k++) rd(rst_a[k], rst_v[k]);
    v = 8'($random(seed));
    wr(8'h12, v);
    rd(8'h12, v);
    done("irq");
    wr(8'h11, 8'hfb);
    wr(8'h12, 8'hfd);
    pulse(16'h0008);
    pin(2'b11);
    rd(8'h16, 8'h08);
    pulse(16'h0204);
    pin(2'b00);
    rd(8'h80, 8'h05);
    pulse(16'h0204);
    rd(8'h17, 8'h02);
    pin(2'b00);
    rd(8'h16, 8'h04);
    pin(2'b11);
    for (int t = 0; t < 4; t++) begin
      wr(8'h40, 8'(t + 4));
      pulse(16'h0004);
      pin(t == 0 ? 2'b11 : {1'b0, t == 1});
      wr(8'h40, 8'(t));
      pin({1'b0, t > 1});
      rd(8'h16, 8'h04);
      pin(t == 0 ? 2'b11 : {1'b0, t == 1});
    end
    // a frozen block drops an event, then runs on as before
    i_clk_en = 0;
    pulse(16'h0004);
    pin(2'b00);
    i_clk_en = 1;
    pin(2'b00);
    pulse(16'h0004);
    pin(2'b01);
    rd(8'h16, 8'h04);
    done("serial");
    for (int s = 0; s < 2; s++) begin
      v = 8'($random(seed));
      i_host_port_mcu.ser_frame(s[0], 8'h11, 1'b0, v, sr);
      exp_q.push_back(v);
      i_host_port_mcu.ser_frame(s[0], 8'h11, 1'b1, v, sr);
      post(sr);
    end
    done("end");
    print_verdict();
  end
endmodule // tb_host_port_irq
bind host_port_irq host_port_irq_sva #(.NSRC(NSRC)) i_host_port_irq_sva (.i_clk_sys(i_clk_sys),
  .i_reset_n(i_reset_n), .i_serial_mode(i_serial_mode), .i_cs_n(i_cs_n), .i_sclk(i_sclk),
  .i_shift_edge_select_pin(i_shift_edge_select_pin), .i_rd_n(i_rd_n), .i_wr_n(i_wr_n), .i_irq_src(i_irq_src),
  .o_data(o_data), .o_data_oe_n(o_data_oe_n), .o_serial_out_pin(o_serial_out_pin), .o_irq(o_irq),
  .o_irq_oe_n(o_irq_oe_n));
